/* mode_supervisor.sv */
// Mode control, watchdog, forced I/O and error history of the controller
`timescale 1ns/1ps

module mode_supervisor
#(
  parameter int WDT_CYCLES   = mode_supervisor_pkg::WDT_CYCLES,
  parameter int BLINK_CYCLES = mode_supervisor_pkg::BLINK_CYCLES,
  parameter int IO_WIDTH     = 16
)
(
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  // Mode requests
  input  wire logic [1:0]           key_position,
  input  wire logic [1:0]           remote_cmd,
  input  wire logic                 stop_instruction,
  // Scan engine handshakes
  input  wire logic                 end_of_scan,
  input  wire logic                 watchdog_restart_instruction,
  input  wire logic                 all_outputs_off_instruction,
  input  wire logic                 immediate_refresh_instruction,
  input  wire logic                 program_valid,
  input  wire logic                 self_diag_error,
  input  wire logic [IO_WIDTH-1:0]  program_outputs,
  // Physical I/O
  input  wire logic [IO_WIDTH-1:0]  phys_inputs,
  output logic      [IO_WIDTH-1:0]  phys_outputs,
  // Real-time clock, BCD
  input  wire logic [15:0]          rtc_year_month,
  input  wire logic [15:0]          rtc_date_hour,
  input  wire logic [15:0]          rtc_minute_second,
  // Special data word port
  input  wire logic                 data_wr,
  input  wire logic [7:0]           data_addr,
  input  wire logic [15:0]          data_wdata,
  input  wire logic                 force_clear,
  output logic      [15:0]          data_rdata,
  // Status to scan engine and lamps
  output logic      [1:0]           op_mode,
  output logic                      program_enable,
  output logic                      data_init,
  output logic      [IO_WIDTH-1:0]  input_image,
  output logic                      run_lamp,
  output logic                      error_lamp
);

  localparam int CW = $clog2(WDT_CYCLES + 1);
  localparam int BW = $clog2(BLINK_CYCLES + 1);

  mode_supervisor_pkg::op_mode_type mode_reg;
  mode_supervisor_pkg::op_mode_type mode_next;
  logic                  halted_reg;
  logic                  wdt_fault_reg;
  logic [CW-1:0]         wdt_count_reg;
  logic [BW-1:0]         blink_count_reg;
  logic                  blink_reg;
  logic                  force_global_enable;
  logic [15:0]           force_input_enable_mask;
  logic [15:0]           force_output_enable_mask;
  logic [15:0]           force_input_data;
  logic [15:0]           force_output_data;
  logic [15:0]           error_history_pointer;
  logic [15:0]           system_error_flag_word;
  logic [IO_WIDTH-1:0]   output_image_reg;
  logic [15:0]           history_mem [0:63];
  logic                  wdt_expire;
  logic                  error_event;
  logic [15:0]           error_code;
  logic                  first_scan_reg;
  logic [5:0]            rec_base;

  // Substitute force data where masked; global enable gates it
  function automatic logic [IO_WIDTH-1:0] apply_force(
    input logic                enable,
    input logic [IO_WIDTH-1:0] raw,
    input logic [IO_WIDTH-1:0] mask,
    input logic [IO_WIDTH-1:0] fdata
  );
    apply_force = enable ? ((raw & ~mask) | (fdata & mask)) : raw;
  endfunction : apply_force

  assign wdt_expire  = (mode_reg == mode_supervisor_pkg::MODE_RUN) &&
                       (wdt_count_reg == CW'(WDT_CYCLES)) && !halted_reg;
  assign error_event = (wdt_expire || self_diag_error) && !halted_reg;
  assign error_code  = wdt_expire ? mode_supervisor_pkg::ERR_WATCHDOG
                                  : mode_supervisor_pkg::ERR_SELF_DIAG;

  // Mode selection: key overrides, remote tool only in remote position
  always_comb
  begin
    mode_next = mode_reg;
    case (key_position)
      mode_supervisor_pkg::KEY_RUN:
      begin
        // Run from remote run stays run, no reinitialisation
        mode_next = mode_supervisor_pkg::MODE_RUN;
      end
      mode_supervisor_pkg::KEY_STOP:
      begin
        mode_next = mode_supervisor_pkg::MODE_STOP;
      end
      mode_supervisor_pkg::KEY_REMOTE:
      begin
        case (remote_cmd)
          mode_supervisor_pkg::REM_RUN:
            mode_next = mode_supervisor_pkg::MODE_RUN;
          mode_supervisor_pkg::REM_STOP:
            mode_next = mode_supervisor_pkg::MODE_STOP;
          mode_supervisor_pkg::REM_PAUSE:
            mode_next = mode_supervisor_pkg::MODE_PAUSE;
          default:
            mode_next = mode_reg;
        endcase
      end
      default:
      begin
        mode_next = mode_reg;
      end
    endcase
    if (stop_instruction && mode_reg == mode_supervisor_pkg::MODE_RUN)
    begin
      mode_next = mode_supervisor_pkg::MODE_STOP;
    end
    if (halted_reg || error_event)
    begin
      mode_next = mode_supervisor_pkg::MODE_STOP;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg <= mode_supervisor_pkg::MODE_STOP;
    end
    else
    begin
      mode_reg <= mode_next;
    end
  end

  // Halt latch: only a reset recovers from an internal error
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      halted_reg    <= 1'b0;
      wdt_fault_reg <= 1'b0;
    end
    else
    begin
      if (error_event)
      begin
        halted_reg <= 1'b1;
      end
      if (wdt_expire)
      begin
        wdt_fault_reg <= 1'b1;
      end
    end
  end

  // Scan watchdog; pause freezes it with the program state
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wdt_count_reg <= '0;
    end
    else if (mode_reg != mode_supervisor_pkg::MODE_RUN || end_of_scan ||
             watchdog_restart_instruction)
    begin
      if (mode_reg != mode_supervisor_pkg::MODE_PAUSE)
      begin
        wdt_count_reg <= '0;
      end
    end
    else if (wdt_count_reg != CW'(WDT_CYCLES))
    begin
      wdt_count_reg <= wdt_count_reg + CW'(1);
    end
  end

  // Program enable and first-scan data init on entry to run from stop
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      first_scan_reg <= 1'b0;
      data_init      <= 1'b0;
      program_enable <= 1'b0;
      op_mode        <= mode_supervisor_pkg::MODE_STOP;
    end
    else
    begin
      op_mode   <= mode_next;
      data_init <= 1'b0;
      // Pause to run resumes held state, so no initialisation then
      if (mode_next == mode_supervisor_pkg::MODE_RUN &&
          mode_reg == mode_supervisor_pkg::MODE_STOP)
      begin
        first_scan_reg <= 1'b1;
        data_init      <= 1'b1;
      end
      else if (end_of_scan)
      begin
        first_scan_reg <= 1'b0;
      end
      // Stop and pause run no steps; output refresh continues, input refresh only in stop
      program_enable <= (mode_next == mode_supervisor_pkg::MODE_RUN) &&
                        program_valid && !first_scan_reg;
    end
  end

  // Output image: cleared on stop entry, updated at end of scan
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      output_image_reg <= '0;
    end
    else if (mode_next == mode_supervisor_pkg::MODE_STOP &&
             mode_reg != mode_supervisor_pkg::MODE_STOP)
    begin
      output_image_reg <= '0;
    end
    else if (mode_reg == mode_supervisor_pkg::MODE_RUN &&
             (end_of_scan || immediate_refresh_instruction))
    begin
      output_image_reg <= program_outputs;
    end
  end

  // Output refresh every cycle in every mode; image stays unforced
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phys_outputs <= '0;
    end
    else if (all_outputs_off_instruction || wdt_fault_reg)
    begin
      phys_outputs <= '0;
    end
    else
    begin
      phys_outputs <= apply_force(force_global_enable, output_image_reg,
                                  force_output_enable_mask,
                                  force_output_data);
    end
  end

  // Input image: refreshed at scan end or on immediate refresh; pause holds
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      input_image <= '0;
    end
    else if (mode_reg != mode_supervisor_pkg::MODE_PAUSE &&
             (end_of_scan || immediate_refresh_instruction ||
              mode_reg == mode_supervisor_pkg::MODE_STOP))
    begin
      input_image <= apply_force(force_global_enable, phys_inputs,
                                 force_input_enable_mask,
                                 force_input_data);
    end
  end

  // Force settings: not touched by mode changes, only by write or clear
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      force_global_enable      <= 1'b0;
      force_input_enable_mask  <= mode_supervisor_pkg::WORD_RESET;
      force_output_enable_mask <= mode_supervisor_pkg::WORD_RESET;
      force_input_data         <= mode_supervisor_pkg::WORD_RESET;
      force_output_data        <= mode_supervisor_pkg::WORD_RESET;
    end
    else if (force_clear)
    begin
      force_global_enable      <= 1'b0;
      force_input_enable_mask  <= mode_supervisor_pkg::WORD_RESET;
      force_output_enable_mask <= mode_supervisor_pkg::WORD_RESET;
      force_input_data         <= mode_supervisor_pkg::WORD_RESET;
      force_output_data        <= mode_supervisor_pkg::WORD_RESET;
    end
    else if (data_wr)
    begin
      if (data_addr == mode_supervisor_pkg::IDX_FORCE_GLOBAL)
        force_global_enable <= data_wdata[0];
      else if (data_addr == mode_supervisor_pkg::IDX_FORCE_IN_MASK)
        force_input_enable_mask <= data_wdata;
      else if (data_addr == mode_supervisor_pkg::IDX_FORCE_OUT_MASK)
        force_output_enable_mask <= data_wdata;
      else if (data_addr == mode_supervisor_pkg::IDX_FORCE_IN_DATA)
        force_input_data <= data_wdata;
      else if (data_addr == mode_supervisor_pkg::IDX_FORCE_OUT_DATA)
        force_output_data <= data_wdata;
    end
  end

  // Error flag word and circular history pointer
  assign rec_base = 6'((error_history_pointer ==
                        16'(mode_supervisor_pkg::HIST_ENTRIES) ?
                        16'h0000 : error_history_pointer) << 2);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      system_error_flag_word <= mode_supervisor_pkg::WORD_RESET;
      error_history_pointer  <= mode_supervisor_pkg::PTR_RESET;
    end
    else if (error_event)
    begin
      system_error_flag_word <= error_code;
      error_history_pointer  <= 16'(rec_base[5:2]) + 16'h0001;
    end
  end

  // History records, four words each; 17th overwrites entry one
  always_ff @(posedge core_clk)
  begin
    if (error_event)
    begin
      history_mem[rec_base]        <= rtc_year_month;
      history_mem[rec_base + 6'd1] <= rtc_date_hour;
      history_mem[rec_base + 6'd2] <= rtc_minute_second;
      history_mem[rec_base + 6'd3] <= error_code;
    end
  end

  // Read port
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_rdata <= 16'h0000;
    end
    else if (data_addr == mode_supervisor_pkg::IDX_FORCE_GLOBAL)
      data_rdata <= {15'h0000, force_global_enable};
    else if (data_addr == mode_supervisor_pkg::IDX_FORCE_IN_MASK)
      data_rdata <= force_input_enable_mask;
    else if (data_addr == mode_supervisor_pkg::IDX_FORCE_OUT_MASK)
      data_rdata <= force_output_enable_mask;
    else if (data_addr == mode_supervisor_pkg::IDX_FORCE_IN_DATA)
      data_rdata <= force_input_data;
    else if (data_addr == mode_supervisor_pkg::IDX_FORCE_OUT_DATA)
      data_rdata <= force_output_data;
    else if (data_addr == mode_supervisor_pkg::IDX_ERR_POINTER)
      data_rdata <= error_history_pointer;
    else if (data_addr == mode_supervisor_pkg::IDX_SYS_ERR_FLAG)
      data_rdata <= system_error_flag_word;
    else if (data_addr >= mode_supervisor_pkg::IDX_HISTORY_BASE &&
             data_addr < mode_supervisor_pkg::IDX_HISTORY_BASE + 8'h40)
      data_rdata <= history_mem[data_addr[5:0]];
    else
      data_rdata <= 16'h0000;
  end

  // Lamps: run lamp off and error lamp blinking after a watchdog fault
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      blink_count_reg <= '0;
      blink_reg       <= 1'b0;
      run_lamp        <= 1'b0;
      error_lamp      <= 1'b0;
    end
    else
    begin
      if (blink_count_reg == BW'(BLINK_CYCLES - 1))
      begin
        blink_count_reg <= '0;
        blink_reg       <= ~blink_reg;
      end
      else
      begin
        blink_count_reg <= blink_count_reg + BW'(1);
      end
      run_lamp   <= (mode_reg == mode_supervisor_pkg::MODE_RUN) &&
                    !halted_reg;
      // Every halt blinks, so the lamp never sits steadily lit
      error_lamp <= halted_reg && blink_reg;
    end
  end

endmodule : mode_supervisor

/* mode_supervisor_pkg.sv */
// Constants and types shared by the controller supervisory block
package mode_supervisor_pkg;

  // Operating modes, Gray coded along stop -> run -> pause
  typedef enum logic [1:0]
  {
    MODE_STOP  = 2'b00,
    MODE_RUN   = 2'b01,
    MODE_PAUSE = 2'b11
  } op_mode_type;

  // Mode key positions
  typedef enum logic [1:0]
  {
    KEY_RUN    = 2'b00,
    KEY_STOP   = 2'b01,
    KEY_REMOTE = 2'b10
  } key_pos_type;

  // Remote commands from the programming tool
  typedef enum logic [1:0]
  {
    REM_NONE  = 2'b00,
    REM_RUN   = 2'b01,
    REM_STOP  = 2'b10,
    REM_PAUSE = 2'b11
  } remote_cmd_type;

  // Special data word indexes
  localparam logic [7:0] IDX_FORCE_GLOBAL    = 8'h00;
  localparam logic [7:0] IDX_FORCE_IN_MASK   = 8'h01;
  localparam logic [7:0] IDX_FORCE_OUT_MASK  = 8'h02;
  localparam logic [7:0] IDX_FORCE_IN_DATA   = 8'h03;
  localparam logic [7:0] IDX_FORCE_OUT_DATA  = 8'h04;
  localparam logic [7:0] IDX_ERR_POINTER     = 8'h05;
  localparam logic [7:0] IDX_SYS_ERR_FLAG    = 8'h06;
  localparam logic [7:0] IDX_HISTORY_BASE    = 8'h40;

  // Error codes
  localparam logic [15:0] ERR_WATCHDOG  = 16'h0001;
  localparam logic [15:0] ERR_SELF_DIAG = 16'h0002;

  // History geometry
  localparam int          HIST_ENTRIES  = 16;
  localparam int          HIST_WORDS    = 4;
  localparam logic [15:0] PTR_RESET     = 16'h0000;
  localparam logic [15:0] WORD_RESET    = 16'h0000;

  // Watchdog period, 200 ms at 40 MHz
  localparam int          CLK_HZ        = 40000000;
  localparam int          WDT_MS        = 200;
  localparam int          WDT_CYCLES    = (CLK_HZ / 1000) * WDT_MS;

  // Error lamp blink half period, 250 ms
  localparam int          BLINK_MS      = 250;
  localparam int          BLINK_CYCLES  = (CLK_HZ / 1000) * BLINK_MS;

endpackage : mode_supervisor_pkg

/* mode_supervisor_checker.sv */
// Concurrent checks on the ports of the controller supervisory block
`timescale 1ns/1ps
module mode_supervisor_checker
#(
  parameter int WDT_CYCLES   = 50,
  parameter int BLINK_CYCLES = 4,
  parameter int IO_WIDTH     = 16
)
(
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                arst_n,
  // Requests
  input wire logic [1:0]          key_position,
  input wire logic                end_of_scan,
  input wire logic                watchdog_restart_instruction,
  input wire logic                all_outputs_off_instruction,
  // Status
  input wire logic [IO_WIDTH-1:0] phys_outputs,
  input wire logic [1:0]          op_mode,
  input wire logic                program_enable,
  input wire logic                data_init,
  input wire logic                run_lamp,
  input wire logic                error_lamp
);
  localparam int LATE      = 4;
  localparam int BLINK_MAX = BLINK_CYCLES + 2;
  int unsigned dog_cnt;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // Any non-run cycle restarts this count, so it only lags the design's
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      dog_cnt <= 0;
    else if (end_of_scan || watchdog_restart_instruction ||
             op_mode != mode_supervisor_pkg::MODE_RUN)
      dog_cnt <= 0;
    else
      dog_cnt <= dog_cnt + 1;
  end
  outputs_off_a: assert property (
    all_outputs_off_instruction |=> phys_outputs == '0)
    else $error("outputs not off after all-off request");
  key_stop_a: assert property (
    key_position == mode_supervisor_pkg::KEY_STOP |=>
    op_mode == mode_supervisor_pkg::MODE_STOP)
    else $error("stop key did not force stop");
  pause_key_a: assert property (
    key_position != mode_supervisor_pkg::KEY_REMOTE |=>
    op_mode != mode_supervisor_pkg::MODE_PAUSE)
    else $error("pause reached without remote key");
  init_pulse_a: assert property (
    $rose(data_init) |-> (op_mode == mode_supervisor_pkg::MODE_RUN &&
    $past(op_mode) == mode_supervisor_pkg::MODE_STOP) ##1 !data_init)
    else $error("data init not a single pulse on stop to run");
  no_exec_a: assert property (
    op_mode != mode_supervisor_pkg::MODE_RUN && $stable(op_mode) |->
    !program_enable)
    else $error("program enabled outside run");
  dog_trip_a: assert property (
    dog_cnt == WDT_CYCLES |-> ##[1:LATE]
    (op_mode == mode_supervisor_pkg::MODE_STOP && phys_outputs == '0 &&
    !run_lamp))
    else $error("watchdog did not halt in time");
  blink_rate_a: assert property (
    $rose(error_lamp) |-> error_lamp[*2] ##[1:BLINK_MAX] !error_lamp)
    else $error("error lamp not blinking");
  halt_lamps_a: assert property (
    error_lamp |-> op_mode == mode_supervisor_pkg::MODE_STOP && !run_lamp)
    else $error("error lamp lit outside halt");
  init_c: cover property ($rose(data_init));
  pause_c: cover property (op_mode == mode_supervisor_pkg::MODE_PAUSE);
  trip_c: cover property ($rose(error_lamp));
endmodule : mode_supervisor_checker

/* mode_tool_model.sv */
// Model of the front mode key and the host programming tool
`timescale 1ns/1ps
module mode_tool_model
(
  // Clock
  input  wire logic       core_clk,
  // Mode request lines
  output logic      [1:0] key_position,
  output logic      [1:0] remote_cmd
);
  initial
  begin
    key_position = mode_supervisor_pkg::KEY_STOP;
    remote_cmd   = mode_supervisor_pkg::REM_NONE;
  end
  // Key and tool command are levels, changed only off the sampling edge
  task automatic set_mode(input logic [1:0] k, input logic [1:0] c);
    @(negedge core_clk);
    key_position = k;
    remote_cmd   = c;
  endtask : set_mode
endmodule : mode_tool_model

/* controller_mode_force_watchdog_tb.sv */
// Self-checking testbench of the controller supervisory block
`timescale 1ns/1ps
module controller_mode_force_watchdog_tb;
  localparam int W = 50;
  wire  [1:0]  key_position, remote_cmd;
  logic        core_clk, arst_n, stop_ins, eos, kick, outs_off, refresh_now;
  logic        prog_ok, diag_err, wr, fclear, init, prog_en, run_lamp;
  logic        err_lamp;
  logic [1:0]  mode;
  logic [7:0]  addr;
  logic [15:0] prog_out, phys_in, phys_out, wdata, rdata, in_img;
  logic [15:0] rtc_ym, rtc_dh, rtc_ms;
  int          n_errors, samples_checked;
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  mode_tool_model u_mode_tool_model
  (.core_clk(core_clk), .key_position(key_position),
   .remote_cmd(remote_cmd));
  mode_supervisor #(.WDT_CYCLES(W), .BLINK_CYCLES(4)) u_mode_supervisor
  (.core_clk(core_clk), .arst_n(arst_n), .key_position(key_position),
   .remote_cmd(remote_cmd), .stop_instruction(stop_ins),
   .end_of_scan(eos), .watchdog_restart_instruction(kick),
   .all_outputs_off_instruction(outs_off),
   .immediate_refresh_instruction(refresh_now), .program_valid(prog_ok),
   .self_diag_error(diag_err), .program_outputs(prog_out),
   .phys_inputs(phys_in), .phys_outputs(phys_out),
   .rtc_year_month(rtc_ym), .rtc_date_hour(rtc_dh),
   .rtc_minute_second(rtc_ms), .data_wr(wr), .data_addr(addr),
   .data_wdata(wdata), .force_clear(fclear), .data_rdata(rdata),
   .op_mode(mode), .program_enable(prog_en), .data_init(init),
   .input_image(in_img), .run_lamp(run_lamp), .error_lamp(err_lamp));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [15:0] e,
                       input logic [15:0] got);
    samples_checked++;
    if (got !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, got);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask : pulse
  task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
    wr    = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge core_clk);
    wr = 1'b0;
    // Idle cycle so a following write never re-raises the strobe at once
    @(negedge core_clk);
  endtask : wr_word
  task automatic rd_word(input logic [7:0] a, input logic [15:0] e,
                         input string what);
    addr = a;
    @(negedge core_clk);
    check(what, e, rdata);
  endtask : rd_word
  task automatic key(input logic [1:0] k, input logic [1:0] c);
    u_mode_tool_model.set_mode(k, c);
    @(negedge core_clk);
  endtask : key
  task automatic do_reset;
    arst_n = 1'b0;
    cyc(12);
    arst_n = 1'b1;
    cyc(1);
  endtask : do_reset
  task automatic t_modes;
    key(mode_supervisor_pkg::KEY_RUN, mode_supervisor_pkg::REM_NONE);
    check("run mode", mode_supervisor_pkg::MODE_RUN, 16'(mode));
    check("init pulse", 16'h0001, 16'(init));
    pulse(eos);
    cyc(2);
    check("program enable", 16'h0001, 16'(prog_en));
    stop_ins = 1'b1;
    cyc(1);
    check("stop instr", mode_supervisor_pkg::MODE_STOP, 16'(mode));
    stop_ins = 1'b0;
    key(mode_supervisor_pkg::KEY_REMOTE, mode_supervisor_pkg::REM_RUN);
    check("remote run", mode_supervisor_pkg::MODE_RUN, 16'(mode));
    key(mode_supervisor_pkg::KEY_REMOTE, mode_supervisor_pkg::REM_PAUSE);
    cyc(1);
    check("pause", mode_supervisor_pkg::MODE_PAUSE, 16'(mode));
    check("pause held", 16'h0000, 16'(prog_en));
    key(mode_supervisor_pkg::KEY_REMOTE, mode_supervisor_pkg::REM_RUN);
    check("resume init", 16'h0000, 16'(init));
    pulse(eos);
    key(mode_supervisor_pkg::KEY_RUN, mode_supervisor_pkg::REM_STOP);
    check("local run", mode_supervisor_pkg::MODE_RUN, 16'(mode));
    check("no reinit", 16'h0000, 16'(init));
    key(mode_supervisor_pkg::KEY_STOP, mode_supervisor_pkg::REM_RUN);
    check("local stop", mode_supervisor_pkg::MODE_STOP, 16'(mode));
    $display("test modes done");
  endtask : t_modes
  task automatic t_force;
    phys_in = 16'h00FF;
    wr_word(mode_supervisor_pkg::IDX_FORCE_IN_MASK, 16'h0F0F);
    wr_word(mode_supervisor_pkg::IDX_FORCE_IN_DATA, 16'hAAAA);
    wr_word(mode_supervisor_pkg::IDX_FORCE_OUT_MASK, 16'h00F0);
    wr_word(mode_supervisor_pkg::IDX_FORCE_OUT_DATA, 16'h0050);
    cyc(2);
    check("input unforced", 16'h00FF, in_img);
    wr_word(mode_supervisor_pkg::IDX_FORCE_GLOBAL, 16'h0001);
    cyc(2);
    check("input forced", 16'h0AFA, in_img);
    check("stop forced out", 16'h0050, phys_out);
    key(mode_supervisor_pkg::KEY_RUN, mode_supervisor_pkg::REM_NONE);
    prog_out = 16'h1234;
    pulse(eos);
    cyc(2);
    check("run forced out", 16'h1254, phys_out);
    outs_off = 1'b1;
    cyc(1);
    check("outputs off", 16'h0000, phys_out);
    outs_off = 1'b0;
    key(mode_supervisor_pkg::KEY_STOP, mode_supervisor_pkg::REM_NONE);
    cyc(3);
    check("stop clears", 16'h0050, phys_out);
    rd_word(mode_supervisor_pkg::IDX_FORCE_OUT_MASK, 16'h00F0, "mask");
    pulse(fclear);
    cyc(2);
    check("force cleared", 16'h00FF, in_img);
    rd_word(mode_supervisor_pkg::IDX_FORCE_IN_DATA, 16'h0000, "fdata");
    $display("test force done");
  endtask : t_force
  task automatic t_refresh;
    key(mode_supervisor_pkg::KEY_RUN, mode_supervisor_pkg::REM_NONE);
    prog_out = 16'h0F00;
    phys_in  = 16'h3C3C;
    cyc(2);
    check("before refresh", 16'h0000, phys_out);
    pulse(refresh_now);
    cyc(1);
    check("refreshed out", 16'h0F00, phys_out);
    check("refreshed in", 16'h3C3C, in_img);
    $display("test refresh done");
  endtask : t_refresh
  task automatic t_watchdog;
    int n;
    n = 0;
    pulse(eos);
    repeat (3)
    begin
      cyc(W - 20);
      pulse(kick);
    end
    check("kept running", mode_supervisor_pkg::MODE_RUN, 16'(mode));
    while (mode !== mode_supervisor_pkg::MODE_STOP && n < 200)
    begin
      cyc(1);
      n++;
    end
    if (n >= 200)
    begin
      n_errors++;
      $display("wrong value watchdog halt expected stop seen run");
      complete_run;
    end
    check("trip delay", 16'h0001, 16'(n >= W - 2 && n <= W + 3));
    cyc(2);
    check("outputs dead", 16'h0000, phys_out);
    check("run lamp", 16'h0000, 16'(run_lamp));
    n = 0;
    repeat (16)
    begin
      cyc(1);
      n += 32'(err_lamp);
    end
    check("lamp blinks", 16'h0001, 16'(n > 3 && n < 13));
    rd_word(mode_supervisor_pkg::IDX_SYS_ERR_FLAG, 16'h0001, "flag");
    rd_word(mode_supervisor_pkg::IDX_ERR_POINTER, 16'h0001, "pointer");
    rd_word(8'h40, rtc_ym, "year month");
    rd_word(8'h41, rtc_dh, "date hour");
    rd_word(8'h42, rtc_ms, "minute second");
    rd_word(8'h43, mode_supervisor_pkg::ERR_WATCHDOG, "code");
    check("halt held", mode_supervisor_pkg::MODE_STOP, 16'(mode));
    $display("test watchdog done");
  endtask : t_watchdog
  task automatic t_diag;
    do_reset;
    key(mode_supervisor_pkg::KEY_RUN, mode_supervisor_pkg::REM_NONE);
    pulse(diag_err);
    cyc(2);
    check("diag halt", mode_supervisor_pkg::MODE_STOP, 16'(mode));
    rd_word(mode_supervisor_pkg::IDX_SYS_ERR_FLAG, 16'h0002, "flag");
    $display("test diagnosis done");
  endtask : t_diag
  initial
  begin
    {arst_n, stop_ins, eos, kick, outs_off, refresh_now, diag_err} = '0;
    {wr, fclear, addr, wdata, prog_out, phys_in} = '0;
    prog_ok = 1'b1;
    rtc_ym = 16'h0305;
    rtc_dh = 16'h2812;
    rtc_ms = 16'h3030;
    n_errors = 0;
    samples_checked = 0;
    do_reset;
    t_modes;
    t_force;
    t_refresh;
    t_watchdog;
    t_diag;
    complete_run;
  end
endmodule : controller_mode_force_watchdog_tb
bind mode_supervisor mode_supervisor_checker
  #(.WDT_CYCLES(WDT_CYCLES), .BLINK_CYCLES(BLINK_CYCLES),
    .IO_WIDTH(IO_WIDTH))
  u_mode_supervisor_checker
  (.core_clk(core_clk), .arst_n(arst_n), .key_position(key_position),
   .end_of_scan(end_of_scan),
   .watchdog_restart_instruction(watchdog_restart_instruction),
   .all_outputs_off_instruction(all_outputs_off_instruction),
   .phys_outputs(phys_outputs), .op_mode(op_mode),
   .program_enable(program_enable), .data_init(data_init),
   .run_lamp(run_lamp), .error_lamp(error_lamp));
